// *** common/bbfs_cfg.svh ***
// Fixed layout and timing constants of the baseband frame scheduler
`ifndef BBFS_CFG_SVH
`define BBFS_CFG_SVH
`define TS_PKT_LEN       188
`define UP_LEN           187
`define CRC_IDX          187
`define HDR_LEN          10
`define NO_PTR           16'hffff
`define CLK_NS           40
`define TAIL_MARGIN_PKTS 2
`define NULL_CNT_MAX     8'hff
`define CRC_INIT         8'h00
`endif

// *** common/bbfs_pkg.sv ***
// Types shared by the baseband frame scheduler
`default_nettype none
package bbfs_pkg;
    typedef enum logic [1:0] {S_IDLE, S_HDR, S_PAD, S_DATA} emit_state_t;
endpackage : bbfs_pkg
`default_nettype wire

// *** rtl/pipe_fifo.sv ***
// Per-pipe byte FIFO with registered read data and occupancy count
`timescale 1ns/1ps
`default_nettype none
module pipe_fifo #(
    parameter int W  = 9,
    parameter int AW = 10
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          srst,
    // Write side
    input  wire logic          wr_en,
    input  wire logic [W-1:0]  wr_data,
    // Read side
    input  wire logic          rd_en,
    output logic      [W-1:0]  rd_data,
    output logic      [AW:0]   count
);
    logic [W-1:0]  mem [2**AW];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic          do_wr;
    logic          do_rd;

    // Writes into a full FIFO are lost; depth is sized so this never occurs
    assign do_wr = wr_en && (count != (AW+1)'(2**AW));
    assign do_rd = rd_en && (count != '0);

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wptr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (do_rd) begin
            rd_data <= mem[rptr];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wptr <= wptr + 1'b1;
            end
            if (do_rd) begin
                rptr <= rptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : pipe_fifo
`default_nettype wire

// *** rtl/bb_frame_scheduler.sv ***
// Mode adaptation and baseband frame scheduling over several pipes
//
// Functional notes
// - Sync byte of every packet is dropped; 187 bytes stored.
// - Deleted-null count byte follows a packet, counting nulls before it.
// - Nulls are kept while the interleaving frame's last frame fills.
// - FIFO depth carries a margin of two packets for fragmentation.
// - Normal mode pointer addresses next whole CRC-8 in the frame.
// - Packet starts ride in the FIFO until the header is written.
// - Allocation never exceeds the interleaving frame capacity.
// - Regular delivery keeps receiver buffers within their model.
// - One pipe gives a constant frame count per interleaving frame.
// - Several pipes: whole frames per interleaving frame, count varies.
// - Each pipe has its own FIFO whose occupancy is always watched.
// - A pipe holding a full frame of data gets one more frame.
// - Allocated frames are read, headed, sent as interface packets.
// - Running count of frames allocated in this interleaving frame.
// - First frame of a pipe uses threshold less in-band bytes.
// - First frame carries zero padding later replaced by signalling.
// - At full capacity per-pipe block counts are published.
// - Next interleaving frame starts with all pipes in first state.
// - Interleaving frames are delivered once full, at or after regular instants.
// - At window end, padded frames go to the fullest pipe until full.
`timescale 1ns/1ps
`default_nettype none
`include "bbfs_cfg.svh"
module bb_frame_scheduler #(
    parameter int NPIPE        = 2,
    parameter int DF_BYTES     = 256,
    parameter int INBAND_BYTES = 8,
    parameter int IF_FRAMES    = 8,
    parameter int JUMP         = 1,
    parameter int PI_FRAMES    = 1,
    parameter int FRAME_NS     = 250000,
    parameter logic [7:0] CRC_POLY = 8'hd5
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                srst,
    // Transport stream bytes, one lane per pipe
    input  wire logic [NPIPE-1:0]    ts_valid,
    input  wire logic [NPIPE*8-1:0]  ts_data,
    input  wire logic [NPIPE-1:0]    ts_sop,
    input  wire logic [NPIPE-1:0]    ts_null,
    // Static configuration
    input  wire logic                normal_mode,
    input  wire logic                null_delete,
    // Modulator interface packets
    output logic                     mip_valid,
    output logic [7:0]               mip_data,
    output logic                     mip_sop,
    output logic                     mip_eop,
    output logic [7:0]               mip_pipe,
    // Interleaving frame status
    output logic                     if_ready,
    output logic                     blk_valid,
    output logic [NPIPE*8-1:0]       blk_counts,
    output logic [7:0]               alloc_count
);
    localparam int PW = (NPIPE > 1) ? $clog2(NPIPE) : 1;
    // Every FIFO holds a frame per pipe plus the fragmentation margin
    // depth margin
    localparam int NEED = NPIPE * DF_BYTES
                        + `TAIL_MARGIN_PKTS * `TS_PKT_LEN;
    localparam int AW = $clog2(NEED);
    localparam int IF_CYC = JUMP * PI_FRAMES * FRAME_NS / `CLK_NS;
    localparam int TW = $clog2(IF_CYC + 1);
    localparam int FRAME_SPAN = `HDR_LEN + DF_BYTES - 1;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    bbfs_pkg::emit_state_t state;
    logic [AW:0]   occ [NPIPE];
    logic [8:0]    rdq [NPIPE];
    logic [7:0]    blocks [NPIPE];
    logic [7:0]    rd_pos [NPIPE];
    logic [NPIPE-1:0] first;
    logic [NPIPE-1:0] elig;
    logic [7:0]    unit;
    logic [PW-1:0] pick;
    logic [PW-1:0] sel;
    logic          any_elig;
    logic          keep_tail;
    logic          full;
    logic          due;
    logic          win_end;
    logic          start;
    logic          deliver;
    logic          blk_done;
    logic [TW-1:0] tick;
    logic [15:0]   cnt;
    logic [15:0]   take;
    logic [15:0]   next_take;
    logic [15:0]   dcap;
    logic [15:0]   sptr;
    logic [15:0]   next_sptr;
    logic          cur_first;
    logic          emit_v;
    logic          emit_sop;
    logic          emit_eop;
    logic          emit_ff;
    logic [7:0]    emit_byte;
    logic          v1;
    logic          sop1;
    logic          eop1;
    logic          ff1;
    logic [7:0]    b1;
    logic [PW-1:0] p1;

    assign unit = 8'(`UP_LEN) + {7'h0, normal_mode} + {7'h0, null_delete};
    assign full = (alloc_count == 8'(IF_FRAMES));
    assign keep_tail = (alloc_count >= 8'(IF_FRAMES - 1));

    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_step

    ////////////////////////////////////////////////////////////////////////
    // Input side: one FIFO per pipe
    for (genvar g = 0; g < NPIPE; g++) begin : g_pipe
        logic [7:0] wcnt;
        logic [7:0] crc;
        logic [7:0] nulls;
        logic [1:0] tail;
        logic       drop;
        logic       drop_now;
        logic       wr;
        logic [8:0] wdata;
        logic [7:0] din;

        assign din = ts_data[g*8 +: 8];
        assign drop_now = null_delete && ts_null[g] && !keep_tail;
        assign wr = (ts_valid[g] && !ts_sop[g] && wcnt != 8'h00 && !drop)
                    || (tail != 2'd0);
        assign wdata = (tail == 2'd1) ? {1'b0, crc} :
                       (tail == 2'd2) ? {1'b0, nulls} :
                                        {(wcnt == 8'h01), din};

        always_ff @(posedge clk) begin
            if (srst) begin
                wcnt <= 8'h00;
                crc  <= `CRC_INIT;
                nulls <= 8'h00;
                tail <= 2'd0;
                drop <= 1'b0;
            end else if (ts_valid[g] && ts_sop[g]) begin
                wcnt <= 8'h01;
                crc  <= `CRC_INIT;
                drop <= drop_now;
                tail <= 2'd0;
                // count nulls before
                // A sync byte on the count write cycle starts a fresh run
                if (tail == 2'd2) begin
                    nulls <= {7'h00, drop_now};
                end else if (drop_now && nulls != `NULL_CNT_MAX) begin
                    nulls <= nulls + 8'h01;
                end
            end else if (ts_valid[g] && wcnt != 8'h00) begin
                wcnt <= (wcnt == 8'(`UP_LEN)) ? 8'h00 : wcnt + 8'h01;
                if (!drop) begin
                    crc <= crc_step(crc, din);
                end
                if (wcnt == 8'(`UP_LEN) && !drop) begin
                    tail <= normal_mode ? 2'd1 : (null_delete ? 2'd2 : 2'd0);
                end
            end else if (tail == 2'd1) begin
                tail <= null_delete ? 2'd2 : 2'd0;
            end else if (tail == 2'd2) begin
                tail <= 2'd0;
                nulls <= 8'h00;
            end
        end

        pipe_fifo #(.W(9), .AW(AW)) u_fifo (
            .clk     (clk),
            .srst    (srst),
            .wr_en   (wr),
            .wr_data (wdata),
            .rd_en   (emit_ff && sel == PW'(g)),
            .rd_data (rdq[g]),
            .count   (occ[g])
        );

        assign elig[g] = first[g]
            ? (occ[g] >= (AW+1)'(DF_BYTES - INBAND_BYTES))
            : (occ[g] >= (AW+1)'(DF_BYTES));

        sync_strip_a: assert property (ts_valid[g] && ts_sop[g] && tail == 0
            |-> !wr) else $error("sync byte entered the FIFO");
        count_after_a: assert property (
            tail == 2'd2 && $past(tail) == 2'd1 |-> wdata[7:0] == $past(nulls))
            else $error("bad null count");
        tail_keep_a: assert property (keep_tail && ts_valid[g] && ts_sop[g]
            |=> !drop) else $error("tail null packet deleted");
        null_drop_c: cover property (ts_valid[g] && ts_sop[g] && drop_now);
    end

    ////////////////////////////////////////////////////////////////////////
    // Pipe choice, length and sync pointer for the next frame
    always_comb begin
        logic [7:0]  idx;
        logic [15:0] off;
        logic [AW:0] best;
        idx = 8'h00;
        off = 16'h0000;
        best = '0;
        pick = '0;
        any_elig = 1'b0;
        for (int p = 0; p < NPIPE; p++) begin
            if (elig[p] && !any_elig) begin
                pick = PW'(p);
                any_elig = 1'b1;
            end
        end
        if (due && !any_elig) begin
            for (int p = 0; p < NPIPE; p++) begin
                if (occ[p] > best) begin
                    best = occ[p];
                    pick = PW'(p);
                end
            end
        end
        dcap = first[pick] ? 16'(DF_BYTES - INBAND_BYTES) : 16'(DF_BYTES);
        next_take = (16'(occ[pick]) < dcap) ? 16'(occ[pick]) : dcap;
        idx = (rd_pos[pick] == unit) ? 8'h00 : rd_pos[pick];
        if (normal_mode) begin
            off = (idx <= 8'(`CRC_IDX)) ? 16'(8'(`CRC_IDX) - idx)
                : 16'(`CRC_IDX) + 16'(unit) - 16'(idx);
        end else begin
            off = (idx == 8'h00) ? 16'h0000 : 16'(unit - idx);
        end
        next_sptr = (off < next_take) ? 16'(off << 3) : `NO_PTR;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interleaving frame instants
    assign win_end = (tick == TW'(IF_CYC - 1));

    always_ff @(posedge clk) begin
        if (srst) begin
            tick <= '0;
        end else begin
            tick <= win_end ? '0 : tick + 1'b1;
        end
    end

    assign deliver = (state == bbfs_pkg::S_IDLE) && !v1 && full && due;
    assign start = (state == bbfs_pkg::S_IDLE) && !v1 && !full
                   && (any_elig || due);

    ////////////////////////////////////////////////////////////////////////
    // Allocation bookkeeping
    // fixed count, single pipe
    always_ff @(posedge clk) begin
        if (srst) begin
            alloc_count <= 8'h00;
            first       <= '1;
            due         <= 1'b0;
            if_ready    <= 1'b0;
            for (int p = 0; p < NPIPE; p++) begin
                blocks[p] <= 8'h00;
            end
        end else begin
            if_ready <= deliver;
            if (win_end) begin
                due <= 1'b1;
            end
            if (deliver) begin
                alloc_count <= 8'h00;
                first       <= '1;
                due         <= win_end;
                for (int p = 0; p < NPIPE; p++) begin
                    blocks[p] <= 8'h00;
                end
            end else if (start) begin
                alloc_count    <= alloc_count + 8'h01;
                first[pick]    <= 1'b0;
                blocks[pick]   <= blocks[pick] + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            blk_valid  <= 1'b0;
            blk_done   <= 1'b0;
            blk_counts <= '0;
        end else begin
            blk_valid <= full && !blk_done && !deliver;
            if (deliver) begin
                blk_done <= 1'b0;
            end else if (full && !blk_done) begin
                blk_done <= 1'b1;
                for (int p = 0; p < NPIPE; p++) begin
                    blk_counts[p*8 +: 8] <= blocks[p];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame emission
    always_ff @(posedge clk) begin
        if (srst) begin
            state     <= bbfs_pkg::S_IDLE;
            cnt       <= 16'h0000;
            sel       <= '0;
            take      <= 16'h0000;
            sptr      <= 16'h0000;
            cur_first <= 1'b0;
        end else begin
            unique case (state)
                bbfs_pkg::S_IDLE: begin
                    if (start) begin
                        sel       <= pick;
                        take      <= next_take;
                        sptr      <= next_sptr;
                        cur_first <= first[pick];
                        cnt       <= 16'h0000;
                        state     <= bbfs_pkg::S_HDR;
                    end
                end
                bbfs_pkg::S_HDR: begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == 16'(`HDR_LEN - 1)) begin
                        cnt   <= 16'h0000;
                        state <= cur_first ? bbfs_pkg::S_PAD
                                           : bbfs_pkg::S_DATA;
                    end
                end
                bbfs_pkg::S_PAD: begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == 16'(INBAND_BYTES - 1)) begin
                        cnt   <= 16'h0000;
                        state <= bbfs_pkg::S_DATA;
                    end
                end
                bbfs_pkg::S_DATA: begin
                    cnt <= cnt + 16'h0001;
                    if (emit_eop) begin
                        state <= bbfs_pkg::S_IDLE;
                    end
                end
            endcase
        end
    end

    always_comb begin
        emit_v    = 1'b0;
        emit_sop  = 1'b0;
        emit_eop  = 1'b0;
        emit_ff   = 1'b0;
        emit_byte = 8'h00;
        unique case (state)
            bbfs_pkg::S_IDLE: begin
            end
            bbfs_pkg::S_HDR: begin
                emit_v   = 1'b1;
                emit_sop = (cnt == 16'h0000);
                unique case (cnt)
                    16'h0000: emit_byte = {normal_mode, null_delete, 6'(sel)};
                    16'h0001: emit_byte = {7'h00, cur_first};
                    16'h0002: emit_byte = take[12:5];
                    16'h0003: emit_byte = {take[4:0], 3'h0};
                    16'h0004: emit_byte = sptr[15:8];
                    16'h0005: emit_byte = sptr[7:0];
                    default:  emit_byte = 8'h00;
                endcase
            end
            bbfs_pkg::S_PAD: begin
                emit_v = 1'b1;
            end
            bbfs_pkg::S_DATA: begin
                emit_v   = 1'b1;
                emit_ff  = (cnt < take);
                emit_eop = cur_first
                    ? (cnt == 16'(DF_BYTES - INBAND_BYTES - 1))
                    : (cnt == 16'(DF_BYTES - 1));
            end
        endcase
    end

    // Two stages: FIFO read data arrive one cycle after the read
    always_ff @(posedge clk) begin
        if (srst) begin
            v1 <= 1'b0;
            sop1 <= 1'b0;
            eop1 <= 1'b0;
            ff1 <= 1'b0;
            b1 <= 8'h00;
            p1 <= '0;
            mip_valid <= 1'b0;
            mip_sop <= 1'b0;
            mip_eop <= 1'b0;
            mip_data <= 8'h00;
            mip_pipe <= 8'h00;
        end else begin
            v1 <= emit_v;
            sop1 <= emit_sop;
            eop1 <= emit_eop;
            ff1 <= emit_ff;
            b1 <= emit_byte;
            p1 <= sel;
            mip_valid <= v1;
            mip_sop <= sop1;
            mip_eop <= eop1;
            mip_data <= ff1 ? rdq[p1][7:0] : b1;
            mip_pipe <= 8'(p1);
        end
    end

    // Read position inside the stored packet, resynced on each start flag
    // track packet starts
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int p = 0; p < NPIPE; p++) begin
                rd_pos[p] <= 8'h00;
            end
        end else if (ff1) begin
            rd_pos[p1] <= rdq[p1][8] ? 8'h01 : rd_pos[p1] + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // never over capacity
    cap_limit_a: assert property (alloc_count <= 8'(IF_FRAMES))
        else $error("allocation beyond capacity");
    frame_len_a: assert property (mip_sop |-> ##FRAME_SPAN mip_eop)
        else $error("interface packet length wrong");
    count_step_a: assert property (start && !deliver
        |=> alloc_count == $past(alloc_count) + 8'h01)
        else $error("allocation count did not advance");
    pad_zero_a: assert property (state == bbfs_pkg::S_PAD
        |-> ##2 (mip_valid && mip_data == 8'h00))
        else $error("padding byte not zero");
    if_reset_a: assert property (if_ready |-> alloc_count == 8'h00 && &first)
        else $error("next frame not in first state");
    // delivery only at or after an instant
    regular_a: assert property (if_ready |-> $past(due) && $past(full))
        else $error("delivery off the regular instant");
    frame_c: cover property (mip_sop ##1 mip_valid);
    padded_c: cover property (start && due && !any_elig);
    deliver_c: cover property (if_ready);
endmodule : bb_frame_scheduler
`default_nettype wire

// *** test/ts_lane_src.sv ***
// Transport stream source model for one pipe lane
`timescale 1ns/1ps
`default_nettype none
module ts_lane_src (
    // Clock
    input  wire logic       clk,
    // Request from the bench
    input  wire logic       go,
    input  wire logic       is_null,
    // Lane towards the scheduler
    output logic            valid,
    output logic [7:0]      data,
    output logic            sop,
    output logic            null_pkt,
    output logic            busy
);
    int         idx = 0;
    logic       go_q = 1'b0;
    logic       nul = 1'b0;
    logic [7:0] seq = 8'h01;
    initial begin
        valid = 1'b0;
        data = 8'h00;
        sop = 1'b0;
        null_pkt = 1'b0;
        busy = 1'b0;
    end
    always @(posedge clk) go_q <= go;
    // 188 bytes sync first, then two idle cycles with a toggling bus
    always @(negedge clk) begin
        if (!busy && go_q) begin
            busy = 1'b1;
            idx = 0;
            nul = is_null;
        end
        if (busy && idx < 188) begin
            valid = 1'b1;
            sop = (idx == 0);
            null_pkt = nul && (idx == 0);
            data = (idx == 0) ? 8'h47 : (nul ? 8'hee : seq);
            // Zero never occurs in useful data, so zeros mark padding
            if (idx > 0 && !nul) seq = (seq == 8'hff) ? 8'h01 : seq + 8'h01;
            idx++;
        end else if (busy) begin
            valid = 1'b0;
            sop = 1'b0;
            null_pkt = 1'b0;
            data = ~data;
            idx++;
            if (idx >= 190) busy = 1'b0;
        end
    end
endmodule : ts_lane_src
`default_nettype wire

// *** test/bb_frame_scheduler_tb.sv ***
// Self-checking bench for the baseband frame scheduler
`timescale 1ns/1ps
`default_nettype none
`include "bbfs_cfg.svh"
module bb_frame_scheduler_tb;
    localparam int NP = 2, DF = 32, INB = 4, IFN = 4, IFC = 1000;
    logic            clk, mip_valid, mip_sop, mip_eop, if_ready, blk_valid;
    logic            srst = 1'b1, null_delete = 1'b0, first = 1'b0;
    logic            normal = 1'b0;
    logic [NP-1:0]   go = '0, is_null = '0, ts_valid, ts_sop, ts_null, busy;
    logic [15:0]     ts_data, blk_counts, ptr_seen = `NO_PTR;
    logic [7:0]      mip_data, mip_pipe, alloc_count, hi = 8'h00;
    logic [7:0]      q0[$];
    int              n_errors = 0, total_checks = 0;
    int              bidx = 0, nfirst = 0, cyc = 0;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    for (genvar g = 0; g < NP; g++) begin : g_src
        ts_lane_src u_src (.clk(clk), .go(go[g]), .is_null(is_null[g]),
            .valid(ts_valid[g]), .data(ts_data[g*8+:8]), .sop(ts_sop[g]),
            .null_pkt(ts_null[g]), .busy(busy[g]));
    end
    bb_frame_scheduler #(.NPIPE(NP), .DF_BYTES(DF), .INBAND_BYTES(INB),
        .IF_FRAMES(IFN), .JUMP(1), .PI_FRAMES(1), .FRAME_NS(40000)) DUT (
        .clk(clk), .srst(srst), .ts_valid(ts_valid), .ts_data(ts_data),
        .ts_sop(ts_sop), .ts_null(ts_null), .normal_mode(normal),
        .null_delete(null_delete), .mip_valid(mip_valid),
        .mip_data(mip_data), .mip_sop(mip_sop), .mip_eop(mip_eop),
        .mip_pipe(mip_pipe), .if_ready(if_ready), .blk_valid(blk_valid),
        .blk_counts(blk_counts), .alloc_count(alloc_count));
    task automatic chk(input string what, input logic [15:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Monitor: frame length, header, in-band zeros, pipe 0 data bytes
    always @(posedge clk) begin
        cyc <= srst ? 0 : cyc + 1;
        if (srst) bidx = 0;
        else if (mip_valid === 1'b1) begin
            if (bidx == 0) chk("hdr0", {8'h0, normal, null_delete,
                mip_pipe[5:0]}, mip_data);
            if (bidx == 4) hi = mip_data;
            if (bidx == 5 && {hi, mip_data} != `NO_PTR)
                ptr_seen = {hi, mip_data};
            if (bidx == 1) first = mip_data[0];
            if (first && bidx >= `HDR_LEN && bidx < `HDR_LEN + INB)
                chk("inband", 16'h0, mip_data);
            if (bidx >= `HDR_LEN && mip_data != 8'h00 && mip_pipe == 8'h00)
                q0.push_back(mip_data);
            bidx++;
            if (mip_eop === 1'b1) begin
                chk("pkt_len", `HDR_LEN + DF, bidx);
                nfirst += first;
                bidx = 0;
            end
        end
        if (alloc_count > IFN) chk("alloc_cap", IFN, alloc_count);
    end
    task automatic do_reset(input logic nd, input logic nm);
        @(negedge clk);
        srst = 1'b1;
        null_delete = nd;
        normal = nm;
        repeat (20) @(negedge clk);
        srst = 1'b0;
        chk("alloc_rst", 16'h0, alloc_count);
        chk("out_rst", 16'h0, {mip_valid, if_ready, blk_valid});
        q0.delete();
        ptr_seen = `NO_PTR;
        nfirst = 0;
    endtask : do_reset
    task automatic send(input int g, input logic nul);
        while (busy[g] === 1'b1) @(negedge clk);
        @(negedge clk);
        go[g] = 1'b1;
        is_null[g] = nul;
        @(negedge clk);
        go[g] = 1'b0;
        @(negedge clk);
    endtask : send
    task automatic wait_ev(input bit for_if);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((for_if ? if_ready : blk_valid) !== 1'b1 && n < 3000);
        if (n >= 3000) chk("event_timeout", 16'h1, 16'h0);
    endtask : wait_ev
    task automatic t_fill;
        send(0, 1'b0);
        wait_ev(0);
        chk("alloc_full", IFN, alloc_count);
        chk("blk_counts", IFN, blk_counts);
        wait_ev(1);
        chk("if_instant", 16'h1, cyc >= IFC - 5 && cyc <= IFC + 20);
        chk("alloc_clear", 16'h0, alloc_count);
        chk("first_cnt", 16'h1, nfirst);
        $display("test t_fill done");
    endtask : t_fill
    task automatic t_pad;
        wait_ev(0);
        chk("blk_sum", IFN, blk_counts[7:0] + blk_counts[15:8]);
        wait_ev(1);
        chk("q_size", 16'd187, q0.size());
        for (int i = 0; i < 187 && i < q0.size(); i++)
            chk("data", i + 1, q0[i]);
        chk("first_again", 16'h2, nfirst);
        $display("test t_pad done");
    endtask : t_pad
    task automatic t_two;
        send(0, 1'b0);
        send(1, 1'b0);
        wait_ev(0);
        chk("blk_two", IFN, blk_counts[7:0] + blk_counts[15:8]);
        wait_ev(1);
        // Lower pipe index wins ties, so pipe 1 is served in the next one
        wait_ev(0);
        chk("both_pipes", 16'h1,
            blk_counts[7:0] != 0 && blk_counts[15:8] != 0);
        wait_ev(1);
        $display("test t_two done");
    endtask : t_two
    task automatic t_null;
        do_reset(1'b1, 1'b0);
        send(0, 1'b1);
        send(0, 1'b0);
        wait_ev(1);
        wait_ev(1);
        chk("null_size", 16'd188, q0.size());
        if (q0.size() > 0) chk("null_count", 16'h1, q0[q0.size() - 1]);
        $display("test t_null done");
    endtask : t_null
    task automatic t_norm;
        do_reset(1'b1, 1'b1);
        send(0, 1'b0);
        wait_ev(1);
        wait_ev(1);
        // Unit of 189 bytes leaves the CRC 3 bytes into the last data frame
        chk("sync_ptr", 16'h0018, ptr_seen);
        chk("norm_blocks", IFN, blk_counts);
        $display("test t_norm done");
    endtask : t_norm
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        do_reset(1'b0, 1'b0);
        t_fill;
        t_pad;
        t_two;
        t_null;
        t_norm;
        wrap_up;
    end
    // Whole run needs about 8100 cycles
    initial begin
        #(40 * 20000);
        n_errors++;
        wrap_up;
    end
endmodule : bb_frame_scheduler_tb
`default_nettype wire
